// >>> logic/mode_select_pkg.sv
// Shared constants and types for the line clock and cell port mode selector.
// Assumes a single 25 MHz system clock and a simple strobe register port.
package mode_select_pkg;

  // ==================================================================
  // Sizes
  localparam int LINES = 8;
  localparam int QUEUES = 256;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam int SYNTH_W = 16;

  // ==================================================================
  // Register offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_QUEUE_SIG = 8'h08;
  localparam logic [7:0] OFS_LINE_BASE = 8'h10;
  localparam logic [7:0] OFS_LINE_LAST = 8'h2c;

  // ==================================================================
  // Field positions
  localparam int CTL_LOADED = 0;
  localparam int CTL_MULTI_PHY = 1;
  localparam int STS_DRIVE_STRAP = 0;
  localparam int STS_PHY_STRAP = 1;
  localparam int STS_HS_REJECT = 2;
  localparam int QSIG_VALUE = 8;
  localparam int LCFG_FORMAT_LSB = 0;
  localparam int LCFG_CLK_LSB = 2;
  localparam int LCFG_PARTIAL_LSB = 4;

  // ==================================================================
  // Cell payload sizes and synthesizer rates
  localparam logic [5:0] PAYLOAD_WITH_PTR = 6'h2e;
  localparam logic [5:0] PAYLOAD_NO_PTR = 6'h2f;
  localparam logic [15:0] NOMINAL_INCREMENT = 16'h0fd2;

  // ==================================================================
  // Reset values
  localparam logic [9:0] LINE_CFG_RESET = 10'h000;

  // ==================================================================
  // Modes
  typedef enum logic [1:0] {
    unstructured_multi_line = 2'h0,
    unstructured_high_speed = 2'h1,
    structured_multiframe = 2'h2,
    structured_frame = 2'h3
  } line_format_t;

  typedef enum logic [1:0] {
    src_nominal = 2'h0,
    src_loopback = 2'h1,
    src_srts = 2'h2
  } clock_source_t;

  typedef struct packed {
    logic [5:0] partial;
    clock_source_t clk_src;
    line_format_t format;
  } line_structure_config_word_t;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// >>> logic/line_clock_synth.sv
// Phase accumulator that toggles a line clock at a programmable rate.
// Assumes the increment is held steady by the caller between updates.
`timescale 1ns/1ps
module line_clock_synth #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Rate control
  input wire logic [WIDTH-1:0] i_increment,
  // Synthesized clock level
  output logic o_clock
);

  logic [WIDTH-1:0] phase;
  logic [WIDTH:0] next_phase;

  assign next_phase = {1'b0, phase} + {1'b0, i_increment};

  // ==================================================================
  // Accumulator
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      phase <= '0;
    else
      phase <= next_phase[WIDTH-1:0];
  end

  // Each carry is half a period of the output
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_clock <= 1'b0;
    else if (next_phase[WIDTH])
      o_clock <= ~o_clock;
  end

endmodule

// >>> logic/mode_select_top.sv
// Transmit line clock selection, cell port role mapping and per-line
// data format control. Straps come from pads with internal pull-downs.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module mode_select_top
  import mode_select_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [mode_select_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [mode_select_pkg::REG_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [mode_select_pkg::REG_DW-1:0] o_reg_rdata,
  // Straps
  input wire logic i_tx_line_clock_drive_strap,
  input wire logic i_phy_side_strap,
  // Line clocks
  input wire logic [mode_select_pkg::LINES-1:0] i_rx_line_clock,
  input wire logic [mode_select_pkg::LINES-1:0][7:0] i_srts_delta,
  output logic [mode_select_pkg::LINES-1:0] o_tx_line_clock,
  output logic [mode_select_pkg::LINES-1:0] o_tx_line_clock_oe_n,
  // Cell port pins
  input wire logic i_tx_phy_select_n,
  input wire logic i_rx_phy_select_n,
  output logic o_tx_ctl_pin,
  input wire logic i_tx_stat_pin_n,
  output logic o_rx_ctl_pin,
  input wire logic i_rx_stat_pin_n,
  // Cell engine, ATM-layer role
  input wire logic i_atm_tx_enable_n,
  output logic o_atm_tx_full_n,
  input wire logic i_atm_rx_enable_n,
  output logic o_atm_rx_empty_n,
  // Cell engine, PHY role
  input wire logic i_phy_rx_cell_avail,
  output logic o_phy_rx_enable_n,
  input wire logic i_phy_tx_cell_avail,
  output logic o_phy_tx_enable_n,
  output logic o_phy_role,
  // Service decision
  input wire logic [mode_select_pkg::LINES-1:0] i_service_req,
  output logic o_service_valid,
  output logic [2:0] o_service_line,
  // Per-line format view
  output logic [mode_select_pkg::LINES-1:0] o_line_unframed,
  output logic [mode_select_pkg::LINES-1:0] o_line_cas,
  // Queue and cell length query
  input wire logic [7:0] i_query_queue,
  input wire logic [2:0] i_query_line,
  input wire logic i_query_pointer,
  output logic o_queue_cas,
  output logic [5:0] o_payload_len
);
  import mode_select_pkg::*;

  // ==================================================================
  // Functions
  function automatic logic [5:0] payload_len(input logic ptr, input logic [5:0] partial);
    logic [5:0] full;
    full = ptr ? PAYLOAD_WITH_PTR : PAYLOAD_NO_PTR;
    if (partial != 6'h00 && partial < full)
      payload_len = partial;
    else
      payload_len = full;
  endfunction

  function automatic logic [3:0] first_set(input logic [LINES-1:0] req);
    first_set = 4'h0;
    for (int k = LINES - 1; k >= 0; k--)
    begin
      if (req[k])
        first_set = {1'b1, 3'(k)};
    end
  endfunction

  // ==================================================================
  // Register state
  reg_req_t req;
  line_structure_config_word_t line_cfg [LINES];
  logic config_loaded;
  logic multi_phy_mode;
  logic hs_reject;
  logic [7:0] queue_ptr;
  logic queue_no_sig [QUEUES];
  logic strap_taken;
  logic drive_strap;
  logic phy_strap;
  logic line_hit;
  logic [2:0] line_idx;
  logic hs_on_line0;
  line_structure_config_word_t wcfg;

  assign req = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};
  assign line_hit = req.addr >= OFS_LINE_BASE && req.addr <= OFS_LINE_LAST
    && req.addr[1:0] == 2'h0;
  assign line_idx = 3'(req.addr[REG_AW-1:2] - OFS_LINE_BASE[REG_AW-1:2]);
  assign wcfg = line_structure_config_word_t'(req.wdata[9:0]);
  assign hs_on_line0 = line_cfg[0].format == unstructured_high_speed;

  // Strap pads carry pull-downs, so an open strap reads low here
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      strap_taken <= 1'b0;
      drive_strap <= 1'b0;
      phy_strap <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      drive_strap <= i_tx_line_clock_drive_strap;
      phy_strap <= i_phy_side_strap;
    end
  end

  // Control word: load flag stays set until reset
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      config_loaded <= 1'b0;
      multi_phy_mode <= 1'b0;
    end
    else if (req.wr && req.addr == OFS_CONTROL)
    begin
      config_loaded <= config_loaded | req.wdata[CTL_LOADED];
      multi_phy_mode <= req.wdata[CTL_MULTI_PHY];
    end
  end

  // Per-line configuration; high-speed request off line 0 falls back
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      for (int k = 0; k < LINES; k++)
        line_cfg[k] <= line_structure_config_word_t'(LINE_CFG_RESET);
    end
    else if (req.wr && line_hit)
    begin
      line_cfg[line_idx] <= wcfg;
      if (line_idx != 3'h0 && wcfg.format == unstructured_high_speed)
        line_cfg[line_idx].format <= unstructured_multi_line;
    end
  end

  // Sticky reject flag; a new event beats the write-one clear
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      hs_reject <= 1'b0;
    else if (req.wr && line_hit && line_idx != 3'h0
      && wcfg.format == unstructured_high_speed)
      hs_reject <= 1'b1;
    else if (req.wr && req.addr == OFS_STATUS && req.wdata[STS_HS_REJECT])
      hs_reject <= 1'b0;
  end

  // Per-queue signalling suppression table
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      queue_ptr <= 8'h00;
      for (int q = 0; q < QUEUES; q++)
        queue_no_sig[q] <= 1'b0;
    end
    else if (req.wr && req.addr == OFS_QUEUE_SIG)
    begin
      queue_ptr <= req.wdata[7:0];
      queue_no_sig[req.wdata[7:0]] <= req.wdata[QSIG_VALUE];
    end
  end

  // Read data in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_reg_rdata <= '0;
    else if (!req.rd)
      o_reg_rdata <= '0;
    else if (req.addr == OFS_CONTROL)
      o_reg_rdata <= {30'h0, multi_phy_mode, config_loaded};
    else if (req.addr == OFS_STATUS)
      o_reg_rdata <= {29'h0, hs_reject, phy_strap, drive_strap};
    else if (req.addr == OFS_QUEUE_SIG)
      o_reg_rdata <= {23'h0, queue_no_sig[queue_ptr], queue_ptr};
    else if (line_hit)
      o_reg_rdata <= {22'h0, line_cfg[line_idx]};
    else
      o_reg_rdata <= '0;
  end

  // ==================================================================
  // Transmit line clocks
  logic [LINES-1:0] synth_clock;

  for (genvar g = 0; g < LINES; g++)
  begin : g_line
    logic [SYNTH_W-1:0] inc;
    always_comb
    begin
      if (line_cfg[g].clk_src == src_srts)
        inc = NOMINAL_INCREMENT + SYNTH_W'({{8{i_srts_delta[g][7]}}, i_srts_delta[g]});
      else
        inc = NOMINAL_INCREMENT;
    end
    line_clock_synth #(
      .WIDTH(SYNTH_W)
    ) u_synth (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_increment(inc),
      .o_clock(synth_clock[g])
    );
  end

  // Received clocks pass one flop here; synthesized clocks pass the synthesizer flop and this one
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_tx_line_clock <= '0;
    else
    begin
      for (int k = 0; k < LINES; k++)
      begin
        if (!config_loaded || line_cfg[k].clk_src == src_loopback)
          o_tx_line_clock[k] <= i_rx_line_clock[k];
        else
          o_tx_line_clock[k] <= synth_clock[k];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_tx_line_clock_oe_n <= '1;
    else if (config_loaded)
      o_tx_line_clock_oe_n <= '0;
    else
      o_tx_line_clock_oe_n <= {LINES{~(strap_taken & drive_strap)}};
  end

  // ==================================================================
  // Cell port role mapping
  logic tx_sel;
  logic rx_sel;

  assign o_phy_role = phy_strap;
  assign tx_sel = !multi_phy_mode || !i_tx_phy_select_n;
  assign rx_sel = !multi_phy_mode || !i_rx_phy_select_n;

  always_comb
  begin
    if (phy_strap)
    begin
      o_tx_ctl_pin = rx_sel & i_phy_rx_cell_avail;
      o_phy_rx_enable_n = i_tx_stat_pin_n | ~rx_sel;
      o_rx_ctl_pin = tx_sel & i_phy_tx_cell_avail;
      o_phy_tx_enable_n = i_rx_stat_pin_n | ~tx_sel;
      o_atm_tx_full_n = 1'b0;
      o_atm_rx_empty_n = 1'b0;
    end
    else
    begin
      o_tx_ctl_pin = i_atm_tx_enable_n;
      o_atm_tx_full_n = i_tx_stat_pin_n;
      o_rx_ctl_pin = i_atm_rx_enable_n;
      o_atm_rx_empty_n = i_rx_stat_pin_n;
      o_phy_rx_enable_n = 1'b1;
      o_phy_tx_enable_n = 1'b1;
    end
  end

  // ==================================================================
  // Service decision and format view
  logic [3:0] pick;

  assign pick = first_set(i_service_req);

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_service_valid <= 1'b0;
      o_service_line <= 3'h0;
    end
    else if (hs_on_line0)
    begin
      o_service_valid <= i_service_req[0];
      o_service_line <= 3'h0;
    end
    else
    begin
      o_service_valid <= pick[3];
      o_service_line <= pick[2:0];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_line_unframed <= '0;
      o_line_cas <= '0;
    end
    else
    begin
      for (int k = 0; k < LINES; k++)
      begin
        o_line_unframed[k] <= !line_cfg[k].format[1];
        o_line_cas[k] <= line_cfg[k].format == structured_multiframe;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_queue_cas <= 1'b0;
      o_payload_len <= PAYLOAD_NO_PTR;
    end
    else
    begin
      o_queue_cas <= line_cfg[i_query_line].format == structured_multiframe
        && !queue_no_sig[i_query_queue];
      o_payload_len <= payload_len(i_query_pointer, line_cfg[i_query_line].partial);
    end
  end

  // ==================================================================
  // Checks
  a_clock_undriven: assert property (@(posedge i_clk) disable iff (i_reset)
    strap_taken && !drive_strap && !config_loaded |=> o_tx_line_clock_oe_n == '1)
    else $error("line clock driven before load with strap low");

  a_clock_loopback: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_reset && !config_loaded |=> o_tx_line_clock == $past(i_rx_line_clock))
    else $error("receive clock not looped before load");

  a_clock_drive_early: assert property (@(posedge i_clk) disable iff (i_reset)
    strap_taken && drive_strap ##1 !config_loaded |=> o_tx_line_clock_oe_n == '0)
    else $error("line clock not driven before load with strap high");

  a_hs_line_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    req.wr && line_hit && line_idx != 3'h0 && wcfg.format == unstructured_high_speed |=>
      line_cfg[$past(line_idx)].format != unstructured_high_speed ##0 hs_reject)
    else $error("high-speed format accepted off line 0");

  a_hs_service: assert property (@(posedge i_clk) disable iff (i_reset)
    hs_on_line0 && i_service_req == 8'hfe |=> !o_service_valid)
    else $error("other line served while line 0 is high-speed");

  a_service_lowest: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_reset && !hs_on_line0 && i_service_req[0] |=> o_service_valid
      && o_service_line == 3'h0)
    else $error("service pick wrong");

  a_payload_full: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_reset && line_cfg[i_query_line].partial == 6'h00 |=>
      o_payload_len == ($past(i_query_pointer) ? 6'h2e : 6'h2f))
    else $error("full cell payload length wrong");

  a_payload_partial: assert property (@(posedge i_clk) disable iff (i_reset)
    line_cfg[i_query_line].partial == 6'h2a |=> o_payload_len == 6'h2a)
    else $error("partial cell payload length wrong");

  a_phy_rx_map: assert property (@(posedge i_clk) disable iff (i_reset)
    phy_strap && !multi_phy_mode |-> o_tx_ctl_pin == i_phy_rx_cell_avail
      && o_phy_rx_enable_n == i_tx_stat_pin_n)
    else $error("receive handshake not mapped in PHY role");

  a_phy_tx_map: assert property (@(posedge i_clk) disable iff (i_reset)
    phy_strap && multi_phy_mode && i_tx_phy_select_n |-> !o_rx_ctl_pin
      && o_phy_tx_enable_n)
    else $error("deselected PHY answered");

  a_strap_held: assert property (@(posedge i_clk) disable iff (i_reset)
    strap_taken |=> $stable(drive_strap) && $stable(phy_strap))
    else $error("strap value changed after capture");

  c_load: cover property (@(posedge i_clk) disable iff (i_reset)
    $rose(config_loaded) && drive_strap);
  c_hs_line0: cover property (@(posedge i_clk) disable iff (i_reset)
    hs_on_line0 && o_service_valid);
  c_phy_role: cover property (@(posedge i_clk) disable iff (i_reset)
    phy_strap && multi_phy_mode && !i_rx_phy_select_n && o_tx_ctl_pin);
  c_queue_no_sig: cover property (@(posedge i_clk) disable iff (i_reset)
    o_line_cas[0] && !o_queue_cas);

endmodule

// >>> tb/utopia_far_end.sv
// Far-side cell port device: an ATM layer or PHY facing the selector pins.
// Assumes the bench commands the wanted pin levels; pins move just after an edge.
`timescale 1ns/1ps
module utopia_far_end (
  // Clock
  input wire logic i_clk,
  // Wanted levels, bit 0 transmit side, bit 1 receive side
  input wire logic [1:0] i_stat_n,
  input wire logic [1:0] i_select_n,
  // Pins toward the selector
  output logic o_tx_stat_pin_n,
  output logic o_rx_stat_pin_n,
  output logic o_tx_phy_select_n,
  output logic o_rx_phy_select_n
);
  initial
  begin
    o_tx_stat_pin_n = 1'b1;
    o_rx_stat_pin_n = 1'b1;
    o_tx_phy_select_n = 1'b1;
    o_rx_phy_select_n = 1'b1;
  end

  // =====================================================================
  // Pin drive
  always @(posedge i_clk)
  begin
    o_tx_stat_pin_n <= i_stat_n[0];
    o_rx_stat_pin_n <= i_stat_n[1];
    // Active-low selects, one per direction
    o_tx_phy_select_n <= i_select_n[0];
    o_rx_phy_select_n <= i_select_n[1];
  end
endmodule

// >>> tb/line_clock_and_port_mode_select_bench.sv
// Self-checking bench for the line clock and cell port mode selector.
// Assumes a 25 MHz clock and the far-side model in utopia_far_end.
`timescale 1ns/1ps
module line_clock_and_port_mode_select_bench;
  import mode_select_pkg::*;
  logic i_clk, i_reset, wr, rd, drive_strap, phy_strap, tx_sel_n, rx_sel_n;
  logic [7:0] addr, rx_clk, txclk, oe_n, svc_req, unframed, cas, qq;
  logic [31:0] wdata, rdata;
  logic [7:0][7:0] srts;
  logic [1:0] stat_cmd, sel_cmd;
  logic [3:0] eng;
  logic [7:0] toggled;
  logic tx_stat_n, rx_stat_n, tx_ctl, rx_ctl, atm_full_n, atm_empty_n;
  logic phy_rx_en_n, phy_tx_en_n, phy_role, svc_valid, qp, qcas;
  logic [2:0] svc_line, ql;
  logic [5:0] plen;
  logic [9:0] cfg [8];
  int fail_count, checked;

  mode_select_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_tx_line_clock_drive_strap(drive_strap), .i_phy_side_strap(phy_strap),
    .i_rx_line_clock(rx_clk), .i_srts_delta(srts), .o_tx_line_clock(txclk),
    .o_tx_line_clock_oe_n(oe_n), .i_tx_phy_select_n(tx_sel_n),
    .i_rx_phy_select_n(rx_sel_n), .o_tx_ctl_pin(tx_ctl), .i_tx_stat_pin_n(tx_stat_n),
    .o_rx_ctl_pin(rx_ctl), .i_rx_stat_pin_n(rx_stat_n), .i_atm_tx_enable_n(eng[3]),
    .o_atm_tx_full_n(atm_full_n), .i_atm_rx_enable_n(eng[2]),
    .o_atm_rx_empty_n(atm_empty_n), .i_phy_rx_cell_avail(eng[1]),
    .o_phy_rx_enable_n(phy_rx_en_n), .i_phy_tx_cell_avail(eng[0]),
    .o_phy_tx_enable_n(phy_tx_en_n), .o_phy_role(phy_role), .i_service_req(svc_req),
    .o_service_valid(svc_valid), .o_service_line(svc_line), .o_line_unframed(unframed),
    .o_line_cas(cas), .i_query_queue(qq), .i_query_line(ql), .i_query_pointer(qp),
    .o_queue_cas(qcas), .o_payload_len(plen));

  utopia_far_end far (.i_clk(i_clk), .i_stat_n(stat_cmd), .i_select_n(sel_cmd),
    .o_tx_stat_pin_n(tx_stat_n), .o_rx_stat_pin_n(rx_stat_n),
    .o_tx_phy_select_n(tx_sel_n), .o_rx_phy_select_n(rx_sel_n));

  // =====================================================================
  // Clock and receive line clocks
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    rx_clk <= rx_clk + 8'h5b;
  end

  // =====================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(negedge i_clk);
    check(rdata, exp);
  endtask

  task automatic do_reset(input logic ds, input logic ps);
    @(posedge i_clk);
    i_reset <= 1'b1;
    drive_strap <= ds;
    phy_strap <= ps;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    tick(3);
  endtask

  // Pin pattern {tx_ctl, rx_ctl, atm full, atm empty, phy rx en, phy tx en}
  task automatic pins(input logic [1:0] st, input logic [1:0] sl, input logic [3:0] e,
                      input logic [5:0] exp);
    @(posedge i_clk);
    stat_cmd <= st;
    sel_cmd <= sl;
    eng <= e;
    tick(2);
    check({tx_ctl, rx_ctl, atm_full_n, atm_empty_n, phy_rx_en_n, phy_tx_en_n}, exp);
  endtask

  task automatic query(input logic [2:0] l, input logic [7:0] q, input logic p,
                       input logic c, input logic [5:0] len);
    @(posedge i_clk);
    ql <= l;
    qq <= q;
    qp <= p;
    tick(2);
    check({qcas, plen}, {c, len});
  endtask

  task automatic svc(input logic [7:0] req, input logic [3:0] exp);
    @(posedge i_clk);
    svc_req <= req;
    tick(2);
    check({svc_valid, svc_line}, exp);
  endtask

  // Transmit clock equals the receive clock of one cycle before on masked lines
  task automatic follow(input logic [7:0] m);
    logic [7:0] prev;
    repeat (6)
    begin
      prev = rx_clk;
      @(negedge i_clk);
      check(txclk & m, prev & m);
    end
  endtask

  // =====================================================================
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge i_clk);
    fail_count++;
    final_report();
  end

  // =====================================================================
  // Main sequence
  initial
  begin
    {i_reset, wr, rd, drive_strap, phy_strap, qp} = 6'h20;
    {addr, wdata, rx_clk, svc_req, qq, ql} = '0;
    srts = {8{8'h03}};
    stat_cmd = 2'h3;
    sel_cmd = 2'h3;
    eng = 4'hf;
    fail_count = 0;
    checked = 0;
    cfg = '{10'h005, 10'h004, 10'h002, 10'h2ab, 10'h00a, 10'h003, 10'h004, 10'h005};
    // ATM role, clock outputs released until load
    do_reset(1'b0, 1'b0);
    check(oe_n, 8'hff);
    check(plen, 6'h2f);
    rd_reg(OFS_STATUS, 32'h0);
    rd_reg(8'h3c, 32'h0);
    pins(2'b10, 2'b11, 4'b0100, 6'b010111);
    for (int n = 0; n < 8; n++)
    begin
      wr_reg(OFS_LINE_BASE + 8'(4 * n), 32'(cfg[n]));
    end
    for (int n = 0; n < 8; n++)
    begin
      rd_reg(OFS_LINE_BASE + 8'(4 * n), (n == 7) ? 32'h004 : 32'(cfg[n]));
    end
    rd_reg(OFS_STATUS, 32'h4);
    wr_reg(OFS_STATUS, 32'h4);
    rd_reg(OFS_STATUS, 32'h0);
    check(unframed, 8'hc3);
    check(cas, 8'h14);
    wr_reg(OFS_QUEUE_SIG, 32'h105);
    rd_reg(OFS_QUEUE_SIG, 32'h105);
    query(3'd2, 8'h05, 1'b1, 1'b0, 6'h2e);
    query(3'd2, 8'h06, 1'b0, 1'b1, 6'h2f);
    query(3'd3, 8'h06, 1'b1, 1'b0, 6'h2a);
    svc(8'h0c, 4'h0);
    svc(8'h0d, 4'h8);
    wr_reg(OFS_LINE_BASE, 32'h004);
    svc(8'h0c, 4'ha);
    svc(8'h80, 4'hf);
    svc(8'h00, 4'h0);
    check(oe_n, 8'hff);
    wr_reg(OFS_CONTROL, 32'h1);
    tick(2);
    check(oe_n, 8'h00);
    follow(8'hc3);
    // Synthesized lines must show both levels within a few carry periods
    toggled = 8'h00;
    repeat (64)
    begin
      @(negedge i_clk);
      toggled = toggled | {txclk[5:2], ~txclk[5:2]};
    end
    check(toggled, 8'hff);
    @(posedge i_clk);
    drive_strap <= 1'b1;
    phy_strap <= 1'b1;
    tick(2);
    rd_reg(OFS_STATUS, 32'h0);
    check(phy_role, 1'b0);
    // PHY role, receive clocks looped out until load
    do_reset(1'b1, 1'b1);
    check(oe_n, 8'h00);
    follow(8'hff);
    rd_reg(OFS_STATUS, 32'h3);
    check(phy_role, 1'b1);
    pins(2'b01, 2'b11, 4'b0010, 6'b100010);
    wr_reg(OFS_CONTROL, 32'h2);
    pins(2'b00, 2'b00, 4'b0011, 6'b110000);
    pins(2'b00, 2'b01, 4'b0011, 6'b100001);
    pins(2'b00, 2'b10, 4'b0011, 6'b010010);
    final_report();
  end
endmodule
